// *** uswr_pkg.sv ***
// shared constants, register map and carriers of the wake-capable receiver
`default_nettype none
package uswr_pkg;
  // clock and wake timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WAKE_MIN_NS   = 18000;  // stop to wake transit, least
  localparam int unsigned WAKE_MAX_NS   = 65000;  // stop to wake transit, most
  localparam int unsigned WAKE_CYC      = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CNT_W    = 11;
  localparam int unsigned WAKE_BAUD     = 4800;    // only rate in wake reception

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_NDIV = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // control register fields
  localparam int unsigned CTRL_WAKE_EN  = 0;
  localparam int unsigned CTRL_ERR_SUP  = 1;
  localparam int unsigned CTRL_START    = 2;
  localparam int unsigned CTRL_LEN7     = 3;
  localparam int unsigned CTRL_PAR_LSB  = 4;
  localparam int unsigned CTRL_STOP2    = 6;
  localparam int unsigned CTRL_ERR_MASK = 7;
  localparam int unsigned CTRL_PRE_LSB  = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

  // data register fields and divisor reset values
  localparam int unsigned DATA_DIV_LSB = 9;
  localparam logic [6:0]  WDIV_RST     = 7'h69;
  localparam logic [15:0] NDIV_RST     = 16'h00AD;

  // status / mask bit positions
  localparam int unsigned ST_DONE  = 0;
  localparam int unsigned ST_PAR   = 1;
  localparam int unsigned ST_FRM   = 2;
  localparam int unsigned ST_OVR   = 3;
  localparam int unsigned ST_MISS  = 4;
  localparam int unsigned ST_N     = 5;
  localparam int unsigned ST_FULL  = 8;
  localparam int unsigned ST_WAKE  = 9;
  localparam int unsigned ST_BUSY  = 10;

  // parity encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;

  typedef struct packed {
    logic       len7;
    logic [1:0] parity;
    logic       stop2;
  } uswr_fmt_t;

  typedef struct packed {
    logic       done;
    logic       perr;
    logic       ferr;
    logic [7:0] data;
  } uswr_frame_t;
endpackage : uswr_pkg
`default_nettype wire

// *** uswr_rx_core.sv ***
// frame receiver: start detect, bit sampling, parity and stop check
`timescale 1ns/10ps
`default_nettype none
module uswr_rx_core (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               enable,
  input  wire logic               rx,
  input  wire logic [15:0]        bit_cyc,
  input  wire uswr_pkg::uswr_fmt_t fmt,
  output logic                    started,
  output logic                    busy,
  output uswr_pkg::uswr_frame_t   frame
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} uswr_rx_st_t;

  uswr_rx_st_t           st_reg, st_next;
  logic [15:0]           cnt_reg, cnt_next;
  logic [3:0]            bit_reg, bit_next;
  logic [7:0]            sh_reg, sh_next;
  logic                  par_reg, par_next;
  logic                  ferr_reg, ferr_next;
  logic                  perr_reg, perr_next;
  uswr_pkg::uswr_frame_t frame_next;
  logic                  started_next;
  logic                  tick;
  logic [3:0]            nbits;

  assign tick  = (cnt_reg == 16'h0000);
  assign nbits = fmt.len7 ? 4'h7 : 4'h8;
  assign busy  = (st_reg != S_IDLE);

  // sampling state machine; disabling aborts a frame at once
  always_comb begin
    st_next      = st_reg;
    cnt_next     = tick ? 16'h0000 : cnt_reg - 16'h0001;
    bit_next     = bit_reg;
    sh_next      = sh_reg;
    par_next     = par_reg;
    ferr_next    = ferr_reg;
    perr_next    = perr_reg;
    frame_next   = '{done: 1'b0, perr: perr_reg, ferr: ferr_reg, data: frame.data};
    started_next = 1'b0;
    if (!enable) begin
      st_next  = S_IDLE;
      cnt_next = 16'h0000;
    end else begin
      unique case (st_reg)
        S_IDLE: if (!rx) begin
          st_next      = S_START;
          cnt_next     = {1'b0, bit_cyc[15:1]};  // half bit to centre
          started_next = 1'b1;
        end
        S_START: if (tick) begin
          if (rx) begin
            st_next = S_IDLE;  // glitch, not a start bit
          end else begin
            st_next   = S_DATA;
            cnt_next  = bit_cyc - 16'h0001;
            bit_next  = 4'h0;
            par_next  = (fmt.parity == uswr_pkg::PAR_ODD);
            ferr_next = 1'b0;
            perr_next = 1'b0;
          end
        end
        S_DATA: if (tick) begin
          cnt_next = bit_cyc - 16'h0001;
          sh_next  = {rx, sh_reg[7:1]};
          par_next = par_reg ^ rx;
          bit_next = bit_reg + 4'h1;
          if (bit_reg == nbits - 4'h1) begin
            st_next = (fmt.parity == uswr_pkg::PAR_NONE) ? S_STOP : S_PAR;
            bit_next = 4'h0;
          end
        end
        S_PAR: if (tick) begin
          cnt_next  = bit_cyc - 16'h0001;
          perr_next = par_reg ^ rx;
          st_next   = S_STOP;
        end
        S_STOP: if (tick) begin
          cnt_next  = bit_cyc - 16'h0001;
          ferr_next = ferr_reg | !rx;
          bit_next  = bit_reg + 4'h1;
          if (!fmt.stop2 || bit_reg == 4'h1) begin
            st_next         = S_IDLE;
            frame_next.done = 1'b1;
            frame_next.perr = perr_reg;
            frame_next.ferr = ferr_reg | !rx;
            frame_next.data = fmt.len7 ? {1'b0, sh_reg[7:1]} : sh_reg;
          end
        end
        default: st_next = S_IDLE;
      endcase
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= S_IDLE;
      cnt_reg  <= 16'h0000;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      par_reg  <= 1'b0;
      ferr_reg <= 1'b0;
      perr_reg <= 1'b0;
      frame    <= '0;
      started  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      par_reg  <= par_next;
      ferr_reg <= ferr_next;
      perr_reg <= perr_next;
      frame    <= frame_next;
      started  <= started_next;
    end
  end
endmodule : uswr_rx_core
`default_nettype wire

// *** uswr_top.sv ***
// wake-capable serial receiver with apb registers and interrupts
//
// Contract
// R1: without wake armed, receiver stops all communication in stop state.
// R2: armed and stopped, a start edge on the pin begins reception alone.
// R3: software arms wake only while clocked from the on-chip oscillator.
// R4: wake reception runs at 4800 bps only, via its own divisor.
// R5: software sets wake enable before stop, channel start after initialization.
// R6: error mask and suppress bits choose whether errors raise error interrupt.
// R7: suppress set: parity, framing, overrun flags and error interrupt stay quiet.
// R8: software clears error flags and reads data before arming with suppress.
// R9: while armed, only receptions started in stop state are valid.
// R10: software sets wake divisor 105 or 79 and prescaler per oscillator.
// R11: stop to wake reception transit takes between 18 and 65 us.
// R12: wake reception uses the same frame format as normal operation.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module uswr_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_pin,
  input  wire logic        stop_mode,
  input  wire logic        hs_osc_selected,
  output logic             irq,
  output logic             rx_error_irq,
  output logic             wake_state
);
  typedef enum logic [1:0] {W_RUN, W_ARMED, W_PEND, W_WAKE} uswr_wake_st_t;

  // address match, used by both the read mux and the write decode
  function automatic logic uswr_hit(input logic [7:0] a, input logic [7:0] off);
    uswr_hit = (a == off);
  endfunction : uswr_hit

  logic [31:0]             ctrl_reg, ctrl_next;
  logic [6:0]              wdiv_reg, wdiv_next;
  logic [15:0]             ndiv_reg, ndiv_next;
  logic [7:0]              rdata_reg, rdata_next;
  logic                    full_reg, full_next;
  logic [uswr_pkg::ST_N-1:0] stat_reg, stat_next;
  logic [uswr_pkg::ST_N-1:0] mask_reg, mask_next;
  logic [uswr_pkg::ST_N-1:0] ev;
  uswr_wake_st_t           wst_reg, wst_next;
  logic [uswr_pkg::WAKE_CNT_W-1:0] wcnt_reg, wcnt_next;
  logic [31:0]             prdata_next;
  logic                    pready_next, pslverr_next;
  logic                    irq_next, err_irq_next, wake_next;
  logic                    acc, wr, rd, mapped;
  logic                    armed, suppress, core_en, wake_rate;
  logic [15:0]             wake_cyc, bit_cyc;
  logic                    core_started, core_busy;
  uswr_pkg::uswr_frame_t   frame;
  uswr_pkg::uswr_fmt_t     fmt;

  // apb access phase completes on the edge where pready is high
  assign acc    = psel && penable && pready;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign mapped = uswr_hit(paddr, uswr_pkg::OFF_CTRL) || uswr_hit(paddr, uswr_pkg::OFF_DATA)
               || uswr_hit(paddr, uswr_pkg::OFF_NDIV) || uswr_hit(paddr, uswr_pkg::OFF_STAT)
               || uswr_hit(paddr, uswr_pkg::OFF_MASK);

  // arming ignored unless the on-chip oscillator drives the unit
  assign armed    = ctrl_reg[uswr_pkg::CTRL_WAKE_EN] && hs_osc_selected  // R3
                 && ctrl_reg[uswr_pkg::CTRL_START];                     // R5
  assign suppress = ctrl_reg[uswr_pkg::CTRL_ERR_SUP];

  // one frame format for both modes
  assign fmt.len7   = ctrl_reg[uswr_pkg::CTRL_LEN7];                        // R12
  assign fmt.parity = ctrl_reg[uswr_pkg::CTRL_PAR_LSB +: 2];                // R12
  assign fmt.stop2  = ctrl_reg[uswr_pkg::CTRL_STOP2];                       // R12

  // wake bit time is (div+1)*2 prescaled clocks; normal rate is independent
  assign wake_cyc  = 16'((({9'h000, wdiv_reg} + 16'h0001) << 1)
                   << ctrl_reg[uswr_pkg::CTRL_PRE_LSB +: 3]);              // R4 R10
  assign wake_rate = (wst_reg != W_RUN);
  assign bit_cyc   = wake_rate ? wake_cyc : ndiv_reg;                       // R4

  // in stop the receiver runs only while armed; otherwise it is held idle
  assign core_en = ctrl_reg[uswr_pkg::CTRL_START]
                && (!stop_mode || wst_reg != W_RUN);                        // R1 R2

  uswr_rx_core u_core (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (core_en),
    .rx      (serial_rx_pin),
    .bit_cyc (bit_cyc),
    .fmt     (fmt),
    .started (core_started),
    .busy    (core_busy),
    .frame   (frame)
  );

  // wake sequencer: armed in stop, edge starts frame, state shows after transit
  always_comb begin
    wst_next  = wst_reg;
    wcnt_next = wcnt_reg;
    unique case (wst_reg)
      W_RUN:   if (stop_mode && armed) wst_next = W_ARMED;
      W_ARMED: begin
        if (core_started) begin
          wst_next  = W_PEND;                                               // R2
          wcnt_next = '0;
        end else if (!stop_mode || !armed) begin
          wst_next = W_RUN;
        end
      end
      W_PEND: begin
        wcnt_next = wcnt_reg + 1'b1;
        if (wcnt_reg == uswr_pkg::WAKE_CNT_W'(uswr_pkg::WAKE_CYC - 1)) begin
          wst_next = W_WAKE;                                                // R11
        end
      end
      W_WAKE: if (!core_busy) wst_next = (stop_mode && armed) ? W_ARMED : W_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wst_reg  <= W_RUN;
      wcnt_reg <= '0;
    end else begin
      wst_reg  <= wst_next;
      wcnt_reg <= wcnt_next;
    end
  end

  // receive events; suppression keeps error flags quiet
  always_comb begin
    ev                   = '0;
    ev[uswr_pkg::ST_DONE] = frame.done;
    ev[uswr_pkg::ST_PAR]  = frame.done && frame.perr && !suppress;          // R7
    ev[uswr_pkg::ST_FRM]  = frame.done && frame.ferr && !suppress;          // R7
    ev[uswr_pkg::ST_OVR]  = frame.done && full_reg && !suppress;            // R7
    // a start with wake enabled but outside stop may give a corrupt frame
    ev[uswr_pkg::ST_MISS] = core_started && ctrl_reg[uswr_pkg::CTRL_WAKE_EN]
                          && wst_reg == W_RUN;                              // R9
  end

  // register file writes; hardware set beats software clear
  always_comb begin
    ctrl_next  = ctrl_reg;
    wdiv_next  = wdiv_reg;
    ndiv_next  = ndiv_reg;
    mask_next  = mask_reg;
    rdata_next = frame.done ? frame.data : rdata_reg;
    full_next  = full_reg;
    stat_next  = stat_reg;
    if (rd && uswr_hit(paddr, uswr_pkg::OFF_DATA)) full_next = 1'b0;
    if (frame.done) full_next = 1'b1;
    if (wr) begin
      if (uswr_hit(paddr, uswr_pkg::OFF_CTRL)) ctrl_next = {21'h000000, pwdata[10:0]};
      if (uswr_hit(paddr, uswr_pkg::OFF_DATA)) begin
        wdiv_next = pwdata[uswr_pkg::DATA_DIV_LSB +: 7];                    // R10
      end
      if (uswr_hit(paddr, uswr_pkg::OFF_NDIV)) ndiv_next = pwdata[15:0];
      if (uswr_hit(paddr, uswr_pkg::OFF_MASK)) mask_next = pwdata[uswr_pkg::ST_N-1:0];
    end
    for (int i = 0; i < uswr_pkg::ST_N; i++) begin
      if (wr && uswr_hit(paddr, uswr_pkg::OFF_STAT) && pwdata[i]) stat_next[i] = 1'b0;
      if (ev[i]) stat_next[i] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= uswr_pkg::CTRL_RST;
      wdiv_reg  <= uswr_pkg::WDIV_RST;
      ndiv_reg  <= uswr_pkg::NDIV_RST;
      mask_reg  <= '0;
      rdata_reg <= 8'h00;
      full_reg  <= 1'b0;
      stat_reg  <= '0;
    end else begin
      ctrl_reg  <= ctrl_next;
      wdiv_reg  <= wdiv_next;
      ndiv_reg  <= ndiv_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
      full_reg  <= full_next;
      stat_reg  <= stat_next;
    end
  end

  // apb answer one cycle into the access phase; unmapped gives pslverr
  always_comb begin
    pready_next  = psel && penable && !pready;
    pslverr_next = pready_next && !mapped;
    prdata_next  = prdata;
    if (pready_next && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (uswr_hit(paddr, uswr_pkg::OFF_CTRL)) prdata_next = ctrl_reg;
      if (uswr_hit(paddr, uswr_pkg::OFF_DATA)) begin
        prdata_next = {16'h0000, wdiv_reg, 1'b0, rdata_reg};
      end
      if (uswr_hit(paddr, uswr_pkg::OFF_NDIV)) prdata_next = {16'h0000, ndiv_reg};
      if (uswr_hit(paddr, uswr_pkg::OFF_STAT)) begin
        prdata_next = {21'h000000, core_busy, wake_state, full_reg, 3'h0, stat_reg};
      end
      if (uswr_hit(paddr, uswr_pkg::OFF_MASK)) prdata_next = {27'h0000000, mask_reg};
    end
  end

  // interrupt outputs; error line gated by the error mask bit
  always_comb begin
    irq_next     = |(stat_reg & mask_reg);
    err_irq_next = |stat_reg[uswr_pkg::ST_OVR:uswr_pkg::ST_PAR]
                && !ctrl_reg[uswr_pkg::CTRL_ERR_MASK];                      // R6
    wake_next    = (wst_next == W_WAKE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      irq          <= 1'b0;
      rx_error_irq <= 1'b0;
      wake_state   <= 1'b0;
    end else begin
      prdata       <= prdata_next;
      pready       <= pready_next;
      pslverr      <= pslverr_next;
      irq          <= irq_next;
      rx_error_irq <= err_irq_next;
      wake_state   <= wake_next;
    end
  end
endmodule : uswr_top
`default_nettype wire

// *** uswr_chk.sv ***
// assertion checker on the ports of the wake-capable receiver
`timescale 1ns/10ps
`default_nettype none
module uswr_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_rx_pin,
  input wire logic        stop_mode,
  input wire logic        hs_osc_selected,
  input wire logic        irq,
  input wire logic        rx_error_irq,
  input wire logic        wake_state
);
  localparam int WAKE_LO = 358;
  localparam int WAKE_HI = 1300;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [4:0]  mask_reg, mask_next;
  logic [8:0]  high_reg, high_next;
  logic [10:0] since_reg, since_next;
  logic        wr, start_ev;
  logic        woke_reg, woke_next;
  // armed start: falling pin after a long idle run, so data bits are not taken
  assign wr = psel && penable && pready && pwrite;
  assign start_ev = stop_mode && hs_osc_selected && ctrl_reg[uswr_pkg::CTRL_WAKE_EN]
    && ctrl_reg[uswr_pkg::CTRL_START] && !serial_rx_pin && high_reg == 9'h1FF && !wake_state;
  // shadows of control and mask writes, idle run and time since armed start
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (wr && paddr == uswr_pkg::OFF_CTRL) ctrl_next = pwdata;
    if (wr && paddr == uswr_pkg::OFF_MASK) mask_next = pwdata[4:0];
    high_next = !serial_rx_pin ? 9'h000 : (high_reg == 9'h1FF ? high_reg : high_reg + 9'h001);
    since_next = start_ev ? 11'h000 : (since_reg == 11'h7FF ? since_reg : since_reg + 11'h001);
    woke_next = start_ev ? 1'b0 : (woke_reg | wake_state);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 32'h0000_0000;
      mask_reg <= 5'h00;
      high_reg <= 9'h000;
      since_reg <= 11'h7FF;
      woke_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      high_reg <= high_next;
      since_reg <= since_next;
      woke_reg <= woke_next;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_first_access;
    psel && penable && !pready;
  endsequence
  // end of the longest allowed transit after an armed start
  sequence s_window_end;
    since_reg == WAKE_HI;
  endsequence
  ready_wait_a: assert property (s_first_access |=> pready)
    else $error("no answer one cycle into access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  mask_quiet_a: assert property (ctrl_reg[uswr_pkg::CTRL_ERR_MASK] [*2] |-> !rx_error_irq)
    else $error("masked error interrupt raised");
  suppress_quiet_a: assert property ($rose(rx_error_irq) |->
    !($past(ctrl_reg[1], 3) && $past(ctrl_reg[1], 2)) || $past(ctrl_reg[7], 3))
    else $error("error interrupt under suppression");
  irq_mask_a: assert property ($rose(irq) |-> mask_reg != 5'h00)
    else $error("interrupt with all sources masked");
  wake_stop_a: assert property ($rose(wake_state) |-> $past(stop_mode))
    else $error("wake state outside stop");
  wake_delay_a: assert property ($rose(wake_state) |-> since_reg >= WAKE_LO && since_reg <= WAKE_HI)
    else $error("wake transit time out of range");
  wake_start_a: assert property (s_window_end |-> woke_reg)
    else $error("armed start did not wake");
endmodule : uswr_chk
bind uswr_top uswr_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr, .serial_rx_pin, .stop_mode, .hs_osc_selected, .irq,
  .rx_error_irq, .wake_state);
`default_nettype wire

// *** uswr_uart_tx.sv ***
// behavioural far-end serial transmitter driving the receive pin
`timescale 1ns/10ps
`default_nettype none
module uswr_uart_tx (
  input  wire logic                pclk,
  input  wire logic                send,
  input  wire logic [7:0]          data,
  input  wire logic [15:0]         bit_cyc,
  input  wire uswr_pkg::uswr_fmt_t fmt,
  input  wire logic                bad_par,
  input  wire logic                bad_stop,
  output logic                     line,
  output logic                     busy
);
  // one bit cell: set after an edge, held for the whole bit time
  task automatic put(input logic v);
    line <= v;
    repeat (bit_cyc) @(posedge pclk);
  endtask : put
  // line rests high between frames; one process owns line and busy
  // start, data lsb first, optional parity, stop; faults only when asked
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (send === 1'b1) begin
        busy <= 1'b1;
        put(1'b0);
        for (int i = 0; i < (fmt.len7 ? 7 : 8); i++) put(data[i]);
        if (fmt.parity != uswr_pkg::PAR_NONE) put(^(fmt.len7 ? {1'b0, data[6:0]} : data)
          ^ (fmt.parity == uswr_pkg::PAR_ODD) ^ bad_par);
        put(!bad_stop);
        if (fmt.stop2) put(1'b1);
        line <= 1'b1;  // back to idle, else a bad stop bit looks like a new start
        busy <= 1'b0;
      end
    end
  end
endmodule : uswr_uart_tx
`default_nettype wire

// *** uart_snooze_wake_receiver_bench.sv ***
// self-checking bench of the wake-capable serial receiver
`timescale 1ns/10ps
`default_nettype none
module uart_snooze_wake_receiver_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic        rx_error_irq, wake_state, stop_mode, hs_osc, mid_wake;
  logic        tx_send, tx_bp, tx_bs, tx_line, tx_busy;
  logic [7:0]  paddr, tx_data, d;
  logic [15:0] tx_bit;
  logic [6:0]  div;
  logic [2:0]  pre;
  logic [31:0] pwdata, prdata, q, ctrl;
  uswr_pkg::uswr_fmt_t tx_fmt, fm;
  int          n_errors, n_tests, seed, cyc;
  logic [7:0]  rst_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] rst_v [6] = '{32'h0, {16'h0, uswr_pkg::WDIV_RST, 9'h0},
                             {16'h0, uswr_pkg::NDIV_RST}, 32'h0, 32'h0, 32'h0};
  uswr_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .serial_rx_pin(tx_line), .stop_mode, .hs_osc_selected(hs_osc), .irq,
    .rx_error_irq, .wake_state);
  uswr_uart_tx far (.pclk, .send(tx_send), .data(tx_data), .bit_cyc(tx_bit), .fmt(tx_fmt),
    .bad_par(tx_bp), .bad_stop(tx_bs), .line(tx_line), .busy(tx_busy));
  // 50 ns clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function logic [31:0] exp_byte(input logic [7:0] b, input logic len7);
    return {24'h0, len7 ? {1'b0, b[6:0]} : b};
  endfunction : exp_byte
  // control word for a frame format with the channel started
  function logic [31:0] fmt_bits(input uswr_pkg::uswr_fmt_t f);
    return {25'h0, f.stop2, f.parity, f.len7, 3'h4};
  endfunction : fmt_bits
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_word
  task chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task give_verdict;
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // one transfer; entered just after an edge, request held until ready is seen
  task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave takes; only the hang guard ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one frame from the far end, wake state sampled 800 cycles in, which falls inside wake-rate frames only
  task send(input logic [7:0] b);
    int k;
    tx_data <= b;
    tx_send <= 1'b1;
    @(posedge pclk);
    tx_send <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      if (k == 800) mid_wake = wake_state;
    end while ((tx_busy !== 1'b0 || k < 2) && k < 12000);
    if (k >= 12000) n_errors++;
    repeat (40) @(posedge pclk);
  endtask : send
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end
  initial begin
    {seed, n_errors, n_tests, cyc} = {32'h8b188c6a, 96'h0};
    {presetn, psel, penable, pwrite, paddr, pwdata, stop_mode, tx_send, tx_bp, tx_bs} = '0;
    {hs_osc, tx_data, tx_bit, tx_fmt, mid_wake} = {1'b1, 8'h00, 16'h0010, 4'h0, 1'b0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rst_a[i]) begin
      apb(rst_a[i], 1'b0, 32'h0);
      chk_word(q, rst_v[i]);
      chk_bit(err, i == 5);
    end
    apb(8'h14, 1'b1, 32'hFFFF_FFFF);
    chk_bit(err, 1'b1);
    ctrl = $random(seed);
    apb(uswr_pkg::OFF_CTRL, 1'b1, ctrl);
    apb(uswr_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk_word(q, ctrl & 32'h7FF);
    apb(uswr_pkg::OFF_NDIV, 1'b1, 32'h10);
    // every length, parity and stop setting with random bytes
    for (int f = 0; f < 12; f++) begin
      fm = {f[0], 2'((f / 2) % 3), f >= 6};
      tx_fmt <= fm;
      apb(uswr_pkg::OFF_CTRL, 1'b1, fmt_bits(fm));
      d = 8'($random(seed));
      send(d);
      apb(uswr_pkg::OFF_DATA, 1'b0, 32'h0);
      chk_word(q & 32'hFF, exp_byte(d, fm.len7));
      apb(uswr_pkg::OFF_STAT, 1'b1, 32'h1F);
    end
    // parity, framing and overrun, reported then suppressed
    for (int s = 0; s < 2; s++) for (int e = 0; e < 3; e++) begin
      fm = {1'b0, uswr_pkg::PAR_EVEN, 1'b0};
      tx_fmt <= fm;
      ctrl = fmt_bits(fm) | (32'(s) << uswr_pkg::CTRL_ERR_SUP);
      apb(uswr_pkg::OFF_CTRL, 1'b1, ctrl);
      tx_bp <= (e == 0);
      tx_bs <= (e == 1);
      send(8'h5A);
      if (e == 2) send(8'hA5);
      chk_bit(rx_error_irq, s == 0);
      apb(uswr_pkg::OFF_STAT, 1'b0, 32'h0);
      chk_word(q & 32'hE, s ? 32'h0 : 32'h2 << e);
      apb(uswr_pkg::OFF_CTRL, 1'b1, ctrl | 32'h80);
      repeat (2) @(posedge pclk);
      chk_bit(rx_error_irq, 1'b0);
      apb(uswr_pkg::OFF_DATA, 1'b0, 32'h0);
      apb(uswr_pkg::OFF_STAT, 1'b1, 32'h1F);
    end
    tx_bp <= 1'b0;
    tx_bs <= 1'b0;
    // interrupt raised, masked, unmasked and cleared
    apb(uswr_pkg::OFF_MASK, 1'b1, 32'h1);
    send(8'h3C);
    chk_bit(irq, 1'b1);
    for (int m = 0; m < 3; m++) begin
      apb(m == 2 ? uswr_pkg::OFF_STAT : uswr_pkg::OFF_MASK, 1'b1, m == 2 ? 32'h1F : 32'(m));
      repeat (2) @(posedge pclk);
      chk_bit(irq, m == 1);
    end
    apb(uswr_pkg::OFF_DATA, 1'b0, 32'h0);
    // stop without a valid arming: no reception at all
    stop_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      hs_osc <= (i == 0);
      apb(uswr_pkg::OFF_CTRL, 1'b1, fmt_bits(fm) | 32'(i));
      send(8'h96);
      apb(uswr_pkg::OFF_STAT, 1'b0, 32'h0);
      chk_word(q & 32'h1, 32'h0);
    end
    stop_mode <= 1'b0;
    hs_osc <= 1'b1;
    // armed reception in stop at the wake rate, both divisor settings
    for (int i = 0; i < 2; i++) begin
      fm = 4'($random(seed));
      if (fm.parity == 2'h3) fm.parity = uswr_pkg::PAR_ODD;
      pre = 3'($random(seed)) & 3'h1;
      div = i ? 7'h4F : 7'h69;
      tx_fmt <= fm;
      tx_bit <= 16'((32'(div) + 1) * 2 << pre);
      apb(uswr_pkg::OFF_DATA, 1'b1, {16'h0, div, 9'h0});
      apb(uswr_pkg::OFF_CTRL, 1'b1, fmt_bits(fm) | 32'h1 | {21'h0, pre, 8'h0});
      stop_mode <= 1'b1;
      repeat (600) @(posedge pclk);
      d = 8'($random(seed));
      send(d);
      chk_bit(mid_wake, 1'b1);
      chk_bit(wake_state, 1'b0);
      stop_mode <= 1'b0;
      apb(uswr_pkg::OFF_DATA, 1'b0, 32'h0);
      chk_word(q & 32'hFF, exp_byte(d, fm.len7));
      apb(uswr_pkg::OFF_STAT, 1'b0, 32'h0);
      chk_word(q & 32'h1, 32'h1);
      apb(uswr_pkg::OFF_STAT, 1'b1, 32'h1F);
    end
    // a start with wake enabled but outside stop is flagged
    tx_bit <= 16'h0010;
    send(8'h55);
    apb(uswr_pkg::OFF_STAT, 1'b0, 32'h0);
    chk_word(q & 32'h10, 32'h10);
    give_verdict();
  end
endmodule : uart_snooze_wake_receiver_bench
`default_nettype wire
